// *** logic/sia_map.vh ***
// Register map and field constants of the status and interrupt aggregator
`ifndef SIA_MAP_VH
`define SIA_MAP_VH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define SIA_OFS_MSTAT 8'h20
`define SIA_OFS_MMASK 8'h24
`define SIA_OFS_DSTAT 8'h28
`define SIA_OFS_DMASK 8'h2C
`define SIA_OFS_LSTAT 8'h30
`define SIA_OFS_LMASK 8'h34

// ----------------------------------------
// Master status bit positions
// ----------------------------------------
`define SIA_MB_RX_ALIGN 0
`define SIA_MB_TX_ALIGN 1
`define SIA_MB_TESTER 2
`define SIA_MB_SYS_ERR 3
`define SIA_MB_PAR_ERR 4
`define SIA_MB_LB_TMO 14
`define SIA_MB_LB_IRQ 15

// ----------------------------------------
// DMA status bit positions
// ----------------------------------------
`define SIA_DB_RX_CRC 2
`define SIA_DB_RX_ABORT 3
`define SIA_DB_RX_LEN 4
`define SIA_DB_RX_OVFL 5
`define SIA_DB_RX_FREE_RD 6
`define SIA_DB_RX_FREE_ERR 7
`define SIA_DB_RX_SB_RD 8
`define SIA_DB_RX_SB_ERR 9
`define SIA_DB_RX_DONE_WR 10
`define SIA_DB_RX_DONE_ERR 11
`define SIA_DB_TX_UDFL 12
`define SIA_DB_TX_PEND_RD 13
`define SIA_DB_TX_DONE_WR 14
`define SIA_DB_TX_DONE_ERR 15

// ----------------------------------------
// Reset values and implemented bits
// ----------------------------------------
`define SIA_RST_VAL 16'h0000
`define SIA_MSTAT_USED 16'hC01F
`define SIA_DSTAT_USED 16'hFFFC

`endif

// *** logic/sia_stat_reg.v ***
// Clear-on-read status register with per-bit interrupt mask
`timescale 1ns/10ps
`include "sia_map.vh"

module sia_stat_reg #(
  parameter W = 16
) (
  input wire clk,
  input wire sys_rst,
  input wire [W-1:0] set_in,
  input wire rd_clr,
  input wire mask_we,
  input wire [W-1:0] mask_wdata,
  output reg [W-1:0] status_q,
  output reg [W-1:0] mask_q,
  output wire irq
);

  // ----------------------------------------
  // Status and mask storage
  // ----------------------------------------
  reg [W-1:0] status_d;

  // Read clears what was returned; a new event wins over the clear
  always @* begin
    status_d = status_q;
    if (rd_clr) begin
      status_d = {W{1'b0}};
    end
    status_d = status_d | set_in;
  end

  // Registers, all zero after reset
  always @(posedge clk) begin
    if (sys_rst) begin
      status_q <= `SIA_RST_VAL;
      mask_q <= `SIA_RST_VAL;
    end else begin
      status_q <= status_d;
      if (mask_we) begin
        mask_q <= mask_wdata;
      end
    end
  end

  // Mask gates only the request, never the status
  assign irq = |(status_q & mask_q);

endmodule // sia_stat_reg

// *** logic/sia_top.v ***
// Status and interrupt aggregator: three event registers, masks, irq pins
//
// Function
// - Three status registers: master, loop detector and DMA; events set bits.
// - Reading a status register clears its set bits until events recur.
// - Every status bit can raise the host-bus interrupt pin.
// - In configuration mode the host interrupt is also driven on local pin.
// - Each status register has a mask register with one bit per status bit.
// - Status bits record events regardless of mask; mask gates interrupt only.
// - Per-port align irq enables gate port changes into summary bits.
// - Tester reports sync change, bit error, overflow; each maskable there.
// - Host-bus events are always recorded in master status; local-bus ones only outside configuration mode.
// - Bridge mode records local irq input and local ready timeouts.
// - Loop detector status: one bit per port on timeout or pattern found.
// - After timeout the port bit keeps re-setting until detector reset.
// - DMA status flags queue reads, done queue writes and queue errors.
// - DMA status flags FIFO over/underflow and receive CRC/abort/length.
// - Master status at 0020h, bits 0,1,2,3,4,14,15, reset zero.
// - Receive align summary sets when any enabled receive port changes alignment.
// - Transmit align summary sets when any enabled transmit port changes alignment.
// - Tester summary sets on unmasked sync change, bit error or counter overflow.
// - Master mask at 0024h mirrors status bits; one unmasks; resets zero.
// - Loop status at 0030h, its mask at 0034h, matching bit positions.
// - DMA status at 0028h with a companion mask register.
`timescale 1ns/10ps
`include "sia_map.vh"

module sia_top #(
  parameter PORTS = 16,
  parameter AW = 8
) (
  input wire clk,
  input wire sys_rst,
  // Register access port
  input wire [AW-1:0] reg_addr,
  input wire reg_rd,
  input wire reg_wr,
  input wire [15:0] reg_wdata,
  output reg [15:0] reg_rdata,
  output reg reg_rdack,
  // Mode: high selects local bus configuration mode
  input wire local_cfg_mode,
  // Port alignment change pulses and per-port enables
  input wire [PORTS-1:0] port_rx_align_change,
  input wire [PORTS-1:0] port_tx_align_change,
  input wire [PORTS-1:0] rx_align_irq_enable,
  input wire [PORTS-1:0] tx_align_irq_enable,
  // Tester events: sync change, bit error, counter overflow
  input wire tester_sync_change,
  input wire tester_bit_error,
  input wire tester_overflow,
  input wire [2:0] tester_event_mask,
  // Host bus error pulses
  input wire host_system_error,
  input wire host_parity_error,
  // Local bus ready timeout pulse (bridge mode)
  input wire local_bus_timeout_error,
  // Loop detector per port
  input wire [PORTS-1:0] port_loop_detect_event,
  input wire [PORTS-1:0] loop_search_timeout,
  // DMA and receive HDLC event pulses, positions as in the map
  input wire [15:0] dma_event,
  // Host interrupt, open drain
  output wire host_irq_n,
  output wire host_irq_oe_n,
  // Local interrupt pin, two-way
  input wire local_irq_in_n,
  output wire local_irq_out_n,
  output wire local_irq_oe_n
);

  // ----------------------------------------
  // Functions
  // ----------------------------------------

  // Address compare against a register offset
  function addr_hit;
    input [AW-1:0] a;
    input [7:0] ofs;
    begin
      addr_hit = (a == ofs[AW-1:0]);
    end
  endfunction

  // Widen a port vector to the 16-bit register width
  function [15:0] port_word;
    input [PORTS-1:0] v;
    integer i;
    begin
      port_word = 16'h0000;
      for (i = 0; i < PORTS && i < 16; i = i + 1) begin
        port_word[i] = v[i];
      end
    end
  endfunction

  // ----------------------------------------
  // Local interrupt input synchroniser
  // ----------------------------------------
  reg lirq_s1_q;
  reg lirq_s2_q;
  reg lirq_prev_q;
  wire lirq_fall;

  // Two stages before the pin is looked at
  always @(posedge clk) begin
    if (sys_rst) begin
      lirq_s1_q <= 1'b1;
      lirq_s2_q <= 1'b1;
      lirq_prev_q <= 1'b1;
    end else begin
      lirq_s1_q <= local_irq_in_n;
      lirq_s2_q <= lirq_s1_q;
      lirq_prev_q <= lirq_s2_q;
    end
  end

  // Assertion edge of the far-side interrupt
  assign lirq_fall = lirq_prev_q & ~lirq_s2_q;

  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  wire hit_mstat;
  wire hit_mmask;
  wire hit_dstat;
  wire hit_dmask;
  wire hit_lstat;
  wire hit_lmask;

  assign hit_mstat = addr_hit(reg_addr, `SIA_OFS_MSTAT);
  assign hit_mmask = addr_hit(reg_addr, `SIA_OFS_MMASK);
  assign hit_dstat = addr_hit(reg_addr, `SIA_OFS_DSTAT);
  assign hit_dmask = addr_hit(reg_addr, `SIA_OFS_DMASK);
  // loop detector status and mask offsets
  assign hit_lstat = addr_hit(reg_addr, `SIA_OFS_LSTAT);
  assign hit_lmask = addr_hit(reg_addr, `SIA_OFS_LMASK);

  // ----------------------------------------
  // Master event sources
  // ----------------------------------------
  wire rx_align_any;
  wire tx_align_any;
  wire tester_any;
  reg [15:0] mstat_set;

  // enables gate each port into the summary
  assign rx_align_any = |(port_rx_align_change & rx_align_irq_enable);
  assign tx_align_any = |(port_tx_align_change & tx_align_irq_enable);

  // tester events, each with its own mask
  assign tester_any = |({tester_overflow, tester_bit_error, tester_sync_change}
                        & ~tester_event_mask);

  // Collect master set pulses into their bit positions
  always @* begin
    mstat_set = 16'h0000;
    mstat_set[`SIA_MB_RX_ALIGN] = rx_align_any;
    mstat_set[`SIA_MB_TX_ALIGN] = tx_align_any;
    mstat_set[`SIA_MB_TESTER] = tester_any;
    mstat_set[`SIA_MB_SYS_ERR] = host_system_error;
    mstat_set[`SIA_MB_PAR_ERR] = host_parity_error;
    mstat_set[`SIA_MB_LB_TMO] = local_bus_timeout_error & ~local_cfg_mode;
    mstat_set[`SIA_MB_LB_IRQ] = lirq_fall & ~local_cfg_mode;
  end

  // ----------------------------------------
  // Loop detector and DMA sources
  // ----------------------------------------
  wire [15:0] lstat_set;
  wire [15:0] dstat_set;

  // one bit per port; timeout level re-sets every cycle
  assign lstat_set = port_word(port_loop_detect_event | loop_search_timeout);

  // queue, FIFO and receive error events
  assign dstat_set = dma_event & `SIA_DSTAT_USED;

  // ----------------------------------------
  // Status registers with masks
  // ----------------------------------------
  wire [15:0] mstat_q;
  wire [15:0] mmask_q;
  wire [15:0] dstat_q;
  wire [15:0] dmask_q;
  wire [15:0] lstat_q;
  wire [15:0] lmask_q;
  wire m_irq;
  wire d_irq;
  wire l_irq;

  sia_stat_reg #(
    .W(16)
  ) u_mstat (
    .clk(clk),
    .sys_rst(sys_rst),
    .set_in(mstat_set),
    .rd_clr(reg_rd & hit_mstat),
    .mask_we(reg_wr & hit_mmask),
    .mask_wdata(reg_wdata & `SIA_MSTAT_USED),
    .status_q(mstat_q),
    .mask_q(mmask_q),
    .irq(m_irq)
  );

  sia_stat_reg #(
    .W(16)
  ) u_dstat (
    .clk(clk),
    .sys_rst(sys_rst),
    .set_in(dstat_set),
    .rd_clr(reg_rd & hit_dstat),
    .mask_we(reg_wr & hit_dmask),
    .mask_wdata(reg_wdata & `SIA_DSTAT_USED),
    .status_q(dstat_q),
    .mask_q(dmask_q),
    .irq(d_irq)
  );

  sia_stat_reg #(
    .W(16)
  ) u_lstat (
    .clk(clk),
    .sys_rst(sys_rst),
    .set_in(lstat_set),
    .rd_clr(reg_rd & hit_lstat),
    .mask_we(reg_wr & hit_lmask),
    .mask_wdata(reg_wdata & port_word({PORTS{1'b1}})),
    .status_q(lstat_q),
    .mask_q(lmask_q),
    .irq(l_irq)
  );

  // ----------------------------------------
  // Read data path
  // ----------------------------------------
  reg [15:0] rdata_d;

  // Select the addressed register; unmapped reads return zero
  always @* begin
    rdata_d = 16'h0000;
    if (hit_mstat) begin
      rdata_d = mstat_q;
    end else if (hit_mmask) begin
      rdata_d = mmask_q;
    end else if (hit_dstat) begin
      rdata_d = dstat_q;
    end else if (hit_dmask) begin
      rdata_d = dmask_q;
    end else if (hit_lstat) begin
      rdata_d = lstat_q;
    end else if (hit_lmask) begin
      rdata_d = lmask_q;
    end
  end

  // Data and acknowledge one cycle after the read strobe
  always @(posedge clk) begin
    if (sys_rst) begin
      reg_rdata <= 16'h0000;
      reg_rdack <= 1'b0;
    end else begin
      reg_rdack <= reg_rd;
      if (reg_rd) begin
        reg_rdata <= rdata_d;
      end
    end
  end

  // ----------------------------------------
  // Interrupt pins
  // ----------------------------------------
  reg irq_q;

  // any unmasked set bit holds the request
  always @(posedge clk) begin
    if (sys_rst) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= m_irq | d_irq | l_irq;
    end
  end

  // Open drain: pull low only while requesting
  assign host_irq_n = ~irq_q;
  assign host_irq_oe_n = ~irq_q;

  // local pin mirrors host request in configuration mode only
  assign local_irq_out_n = ~irq_q;
  assign local_irq_oe_n = ~(irq_q & local_cfg_mode);

endmodule // sia_top

// *** verification/sia_top_props.sv ***
// Port assertions for the status aggregator
`timescale 1ns/10ps
`include "sia_map.vh"
module sia_top_props #(
  parameter PORTS = 16,
  parameter AW = 8
) (
  input wire clk,
  input wire sys_rst,
  input wire [AW-1:0] reg_addr,
  input wire reg_rd,
  input wire reg_wr,
  input wire [15:0] reg_wdata,
  input wire [15:0] reg_rdata,
  input wire reg_rdack,
  input wire local_cfg_mode,
  input wire host_parity_error,
  input wire host_irq_n,
  input wire host_irq_oe_n,
  input wire local_irq_oe_n
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  // ----------------------------------------
  // Helper: parity mask bit as last written
  // ----------------------------------------
  reg par_on_q;
  always @(posedge clk) begin
    if (sys_rst) begin
      par_on_q <= 1'b0;
    end else if (reg_wr && reg_addr == `SIA_OFS_MMASK) begin
      par_on_q <= reg_wdata[`SIA_MB_PAR_ERR];
    end
  end
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  // read answer
  AST_RD_ACK: assert property (reg_rd |=> reg_rdack)
    else $error("read not answered");
  AST_ACK_CAUSE: assert property (reg_rdack |-> $past(reg_rd))
    else $error("ack without read");
  AST_RDATA_HOLD: assert property (!$past(reg_rd) |-> $stable(reg_rdata))
    else $error("read data moved");
  AST_RST_VAL: assert property ($fell(sys_rst) |-> host_irq_n && host_irq_oe_n
    && local_irq_oe_n && !reg_rdack && reg_rdata == 16'h0000) else $error("bad reset");
  AST_MSTAT_BITS: assert property (reg_rd && reg_addr == `SIA_OFS_MSTAT
    |=> (reg_rdata & ~`SIA_MSTAT_USED) == 16'h0000) else $error("unused bit set");
  AST_UNMAPPED: assert property (reg_rd && reg_addr == 8'h38 |=> reg_rdata == 16'h0000)
    else $error("unmapped not zero");
  AST_PAR_SET: assert property (host_parity_error ##1 !reg_rd ##1
    (reg_rd && reg_addr == `SIA_OFS_MSTAT) |=> reg_rdata[4]) else $error("parity lost");
  // unmasked parity event pulls the host pin
  AST_PAR_IRQ: assert property (host_parity_error && par_on_q
    && !(reg_wr && reg_addr == `SIA_OFS_MMASK) |-> ##2 !host_irq_n)
    else $error("parity irq missing");
  AST_HOST_OD: assert property (host_irq_oe_n == host_irq_n)
    else $error("host pin drive wrong");
  AST_LOCAL_OFF: assert property ((!local_cfg_mode)[*2] |-> local_irq_oe_n)
    else $error("local pin driven");
  AST_LOCAL_CFG: assert property (local_cfg_mode[*3] |-> local_irq_oe_n == host_irq_n)
    else $error("local pin differs");
  // Main scenarios reached
  cover property (!host_irq_n);
  cover property (reg_rdack && reg_rdata != 16'h0000);
  cover property (local_cfg_mode && !local_irq_oe_n);
  cover property (host_parity_error ##2 reg_rd);
endmodule // sia_top_props
bind sia_top sia_top_props #(.PORTS(PORTS), .AW(AW)) u_props (.clk(clk), .sys_rst(sys_rst),
  .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
  .reg_rdata(reg_rdata), .reg_rdack(reg_rdack),
  .local_cfg_mode(local_cfg_mode), .host_parity_error(host_parity_error),
  .host_irq_n(host_irq_n), .host_irq_oe_n(host_irq_oe_n), .local_irq_oe_n(local_irq_oe_n));

// *** verification/sia_host.sv ***
// Host model: register strobes, released lines inverted
`timescale 1ns/10ps
module sia_host (
  input wire clk,
  output reg [7:0] reg_addr,
  output reg reg_rd,
  output reg reg_wr,
  output reg [15:0] reg_wdata
);
  initial {reg_addr, reg_rd, reg_wr, reg_wdata} = 0;
  // One write strobe, no answer
  task wr(input [7:0] a, input [15:0] d);
    @(posedge clk) {reg_addr, reg_wdata, reg_wr} <= {a, d, 1'b1};
    @(posedge clk) {reg_addr, reg_wdata, reg_wr} <= {~a, ~d, 1'b0};
  endtask
  // One read strobe, ack follows
  task rd(input [7:0] a);
    @(posedge clk) {reg_addr, reg_rd} <= {a, 1'b1};
    @(posedge clk) {reg_addr, reg_rd} <= {~a, 1'b0};
  endtask
endmodule // sia_host

// *** verification/sia_top_test.sv ***
// Self-checking bench for the status aggregator
`timescale 1ns/10ps
`include "sia_map.vh"
module sia_top_test;
  reg clk = 0, sys_rst = 1, cfg = 0, local_irq_n_n = 1, se = 0, pe = 0, lbt = 0;
  reg [15:0] rxc = 0, txc = 0, rxe = 0, txe = 0, lpe = 0, lto = 0, dma = 0, r;
  reg [2:0] tst = 0, tmsk = 0;
  reg [3:0] p;
  integer seed = 32'h944a_6f2e, failures = 0, n_compared = 0;
  reg [15:0] q[$];
  wire [7:0] addr;
  wire rd, wr, rdack, hirq_n, hoe_n, lout_n, loe_n;
  wire [15:0] wdata, rdata;
  wire host_pin = hoe_n ? 1'b1 : hirq_n;
  wire local_pin = loe_n ? local_irq_n_n : lout_n;
  always #4 clk = ~clk;
  sia_host h (.clk(clk), .reg_addr(addr), .reg_rd(rd), .reg_wr(wr), .reg_wdata(wdata));
  sia_top dut (.clk(clk), .sys_rst(sys_rst), .reg_addr(addr), .reg_rd(rd), .reg_wr(wr),
    .reg_wdata(wdata), .reg_rdata(rdata), .reg_rdack(rdack), .local_cfg_mode(cfg),
    .port_rx_align_change(rxc), .port_tx_align_change(txc), .rx_align_irq_enable(rxe),
    .tx_align_irq_enable(txe), .tester_sync_change(tst[0]), .tester_bit_error(tst[1]),
    .tester_overflow(tst[2]), .tester_event_mask(tmsk), .host_system_error(se),
    .host_parity_error(pe), .local_bus_timeout_error(lbt), .port_loop_detect_event(lpe),
    .loop_search_timeout(lto), .dma_event(dma), .host_irq_n(hirq_n), .host_irq_oe_n(hoe_n),
    .local_irq_in_n(local_pin), .local_irq_out_n(lout_n), .local_irq_oe_n(loe_n));
  task chk(input [15:0] seen, input [15:0] exp);
    n_compared = n_compared + 1;
    if (seen !== exp) begin
      failures = failures + 1;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task rd_x(input [7:0] a, input [15:0] e);
    q.push_back(e);
    h.rd(a);
  endtask
  task tick(input integer n);
    @(posedge clk) {rxc, txc, tst, se, pe, lbt, lpe, dma} <= 0;
    repeat (n) @(posedge clk);
  endtask
  task wrap_up;
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // Read answers in issue order
  always @(negedge clk) if (rdack === 1'b1) begin
    if (q.size() == 0) chk(rdata, 16'hxxxx);
    else chk(rdata, q.pop_front());
  end
  // Hang guard
  initial begin
    repeat (20000) @(posedge clk);
    failures = failures + 1;
    wrap_up;
  end
  // Main sequence
  initial begin
    repeat (20) @(posedge clk);
    sys_rst <= 1'b0;
    for (int i = 0; i < 7; i++) rd_x(8'h20 + 8'(4 * i), 16'h0000);
    $display("test reset done");
    // every master source, random tester mask
    r = 16'($random(seed));
    p = 4'($random(seed));
    {rxe, txe, tmsk} <= {16'h0001 << p, 16'h8000, r[2:0]};
    @(posedge clk) {rxc, txc, tst, se, pe, lbt} <= {16'h0001 << p, 16'h8000, 3'b111, 3'b111};
    local_irq_n_n <= 1'b0;
    tick(5);
    local_irq_n_n <= 1'b1;
    @(negedge clk) chk(16'(host_pin), 16'h0001);
    rd_x(`SIA_OFS_MSTAT, (&r[2:0]) ? 16'hc01b : `SIA_MSTAT_USED);
    rd_x(`SIA_OFS_MSTAT, 16'h0000);
    // bench scans the 16 receive enable bits for the changer
    for (int i = 0; i < 16; i++) if (rxe[i]) r[3:0] = 4'(i);
    chk(16'(r[3:0]), 16'(p));
    $display("test sources done");
    {cfg, tmsk} <= {1'b1, 3'b111};
    @(posedge clk) {rxc, txc, tst, lbt} <= {~rxe, ~txe, 3'b111, 1'b1};
    local_irq_n_n <= 1'b0;
    tick(5);
    {cfg, local_irq_n_n} <= 2'b01;
    rd_x(`SIA_OFS_MSTAT, 16'h0000);
    $display("test refusals done");
    r = 16'($random(seed));
    h.wr(`SIA_OFS_MMASK, 16'hffff);
    h.wr(`SIA_OFS_DMASK, 16'hffff);
    h.wr(`SIA_OFS_LMASK, r);
    h.wr(`SIA_OFS_MSTAT, 16'hffff);
    rd_x(`SIA_OFS_MMASK, `SIA_MSTAT_USED);
    rd_x(`SIA_OFS_DMASK, `SIA_DSTAT_USED);
    rd_x(`SIA_OFS_LMASK, r);
    rd_x(`SIA_OFS_MSTAT, 16'h0000);
    $display("test masks done");
    h.wr(`SIA_OFS_MMASK, 16'h0010);
    h.wr(`SIA_OFS_LMASK, 16'h0000);
    @(posedge clk) se <= 1'b1;
    tick(3);
    @(negedge clk) chk(16'(host_pin), 16'h0001);
    @(posedge clk) {pe, cfg} <= 2'b11;
    @(posedge clk) pe <= 1'b0;
    rd_x(`SIA_OFS_MSTAT, 16'h0018);
    @(negedge clk) chk(16'({host_pin, local_pin}), 16'h0000);
    tick(2);
    @(negedge clk) chk(16'(host_pin), 16'h0001);
    @(posedge clk) cfg <= 1'b0;
    $display("test pins done");
    p = 4'($random(seed));
    @(posedge clk) lto[p] <= 1'b1;
    tick(2);
    rd_x(`SIA_OFS_LSTAT, 16'h0001 << p);
    rd_x(`SIA_OFS_LSTAT, 16'h0001 << p);
    @(posedge clk) lto[p] <= 1'b0;
    rd_x(`SIA_OFS_LSTAT, 16'h0001 << p);
    rd_x(`SIA_OFS_LSTAT, 16'h0000);
    // loop and DMA requests on the host pin
    r = 16'($random(seed));
    h.wr(`SIA_OFS_DMASK, 16'h0000);
    h.wr(`SIA_OFS_LMASK, 16'hffff);
    @(posedge clk) {lpe, dma} <= {r, ~r};
    tick(1);
    @(negedge clk) chk(16'(host_pin), 16'(r == 16'h0000));
    rd_x(`SIA_OFS_LSTAT, r);
    tick(0);
    @(negedge clk) chk(16'(host_pin), 16'h0001);
    h.wr(`SIA_OFS_DMASK, 16'hffff);
    tick(1);
    @(negedge clk) chk(16'(host_pin), 16'((~r & `SIA_DSTAT_USED) == 16'h0000));
    rd_x(`SIA_OFS_DSTAT, ~r & `SIA_DSTAT_USED);
    tick(1);
    @(negedge clk) chk(16'(host_pin), 16'h0001);
    $display("test loop and dma done");
    repeat (4) @(posedge clk);
    if (q.size() != 0) failures = failures + 1;
    wrap_up;
  end
endmodule // sia_top_test
